// File: rtl/rhp_pkg.sv
// Package for the remote host port configuration block
`default_nettype none
package rhp_pkg;
    // Field positions of remote_port_config
    localparam int BIT_IRQ_STATUS = 7;
    localparam int BIT_SSTEP      = 6;
    localparam int BIT_FAST_WR    = 5;
    localparam int BIT_LATCH_RD   = 4;
    localparam int BIT_LATCH_WR   = 3;
    localparam int BIT_RUN        = 2;
    localparam int BIT_MSEL_HI    = 1;
    localparam int BIT_MSEL_LO    = 0;
    // Reset pattern: all low except mem select pointing at instruction memory
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam int IRQ_MASK_BIT = 3;

    // Memory select codes
    localparam logic [1:0] SEL_DMEM = 2'h0;
    localparam logic [1:0] SEL_IMEM = 2'h1;
    localparam logic [1:0] SEL_PCL  = 2'h2;
    localparam logic [1:0] SEL_PCH  = 2'h3;

    // Access mode bundle decoded from the configuration
    typedef struct packed {
        logic latch_rd;
        logic latch_wr;
        logic fast_wr;
    } rhp_mode_t;

    // Core sequencing states
    typedef enum logic [1:0] {CORE_IDLE, CORE_RUN, CORE_STEP} rhp_core_t;
endpackage : rhp_pkg
`default_nettype wire

// File: rtl/rhp_port.sv
// Remote host port configuration, core run control and data arbiter
`default_nettype none
module rhp_port
    import rhp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Remote host pins (asynchronous)
    input  wire logic       cmd_select_pin,
    input  wire logic       remote_access_enable_pin_b,
    input  wire logic       remote_read_strobe_b,
    input  wire logic       remote_write_strobe_b,
    input  wire logic [7:0] remote_data_in,
    output logic      [7:0] remote_data_out,
    output logic            remote_data_oe,
    // Bidirectional interrupt pin
    input  wire logic       bidir_interrupt_pin_in,
    output logic            bidir_interrupt_pin_out,
    output logic            bidir_interrupt_pin_oe,
    // Local control from the core side
    input  wire logic       remote_lockout_bit,
    input  wire logic       bus_hold_pin_b,
    input  wire logic       irq_pin_is_output,
    input  wire logic       core_instr_done,
    input  wire logic       core_dmem_req,
    input  wire logic [7:0] imem_rd_data,
    input  wire logic [7:0] dmem_rd_data,
    // Core and memory steering
    output logic            core_running,
    output logic            core_exec,
    output logic     [15:0] prog_counter,
    output logic      [1:0] host_target,
    output logic            host_target_strobe,
    output logic            host_target_write,
    output logic      [7:0] host_wr_data,
    output logic            grant_core,
    output logic            grant_host,
    output var rhp_mode_t   access_mode
);

    // Two-stage synchronisers for the remote host pins and the interrupt pin input
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [7:0] din_a;
    logic [7:0] din_b;
    always_ff @(posedge clk_sys) begin
        sync_a <= {cmd_select_pin, remote_access_enable_pin_b,
                   remote_read_strobe_b, remote_write_strobe_b,
                   bidir_interrupt_pin_in};
        sync_b <= sync_a;
        din_a  <= remote_data_in;
        din_b  <= din_a;
    end

    logic cmd_s;
    logic rae_b_s;
    logic rd_b_s;
    logic wr_b_s;
    logic irq_in_s;
    assign cmd_s    = sync_b[4];
    assign rae_b_s  = sync_b[3];
    assign rd_b_s   = sync_b[2];
    assign wr_b_s   = sync_b[1];
    assign irq_in_s = sync_b[0];

    // Strobe edge detection works on synchronised copies only
    logic rd_prev;
    logic wr_prev;
    always_ff @(posedge clk_sys) begin
        rd_prev <= rd_b_s;
        wr_prev <= wr_b_s;
    end

    logic rd_start;
    logic wr_start;
    logic port_on;
    logic cfg_hit;
    logic mem_hit;
    assign rd_start = rd_prev & ~rd_b_s;
    assign wr_start = wr_prev & ~wr_b_s;
    assign port_on  = ~rae_b_s;
    assign cfg_hit  = port_on & cmd_s & ~remote_lockout_bit;
    assign mem_hit  = port_on & ~cmd_s;

    // Configuration register
    logic [7:0] cfg;
    logic       mask3;
    rhp_core_t  core_st;
    logic       boot_run;

    // Run, step and mode bits; step bit self-clears once accepted
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg <= CFG_RESET;
        end else begin
            if (cfg_hit && wr_start) begin
                cfg[6:0] <= din_b[6:0];
            end else if (core_st == CORE_STEP) begin
                cfg[BIT_SSTEP] <= 1'b0;
            end
            if (boot_run) begin
                cfg[BIT_RUN] <= 1'b1;
            end
        end
    end

    // Strap catch: pins sampled while reset is held, acted on at release
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            boot_run <= ~rd_b_s & ~wr_b_s & rae_b_s;
        end else begin
            boot_run <= 1'b0;
        end
    end

    // Third mask bit drives the interrupt pin when it is an output
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask3 <= 1'b0;
        end else if (cfg_hit && wr_start && din_b[BIT_IRQ_STATUS]
                     && irq_pin_is_output) begin
            mask3 <= ~mask3;
        end else if (!irq_pin_is_output) begin
            mask3 <= irq_in_s;
        end
    end

    // Core sequencer
    logic step_req;
    assign step_req = cfg[BIT_SSTEP] & ~cfg[BIT_RUN];
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            core_st <= CORE_IDLE;
        end else begin
            case (core_st)
                CORE_IDLE: begin
                    if (cfg[BIT_RUN]) begin
                        core_st <= CORE_RUN;
                    end else if (step_req) begin
                        core_st <= CORE_STEP;
                    end
                end
                CORE_RUN: begin
                    if (!cfg[BIT_RUN] && core_instr_done) begin
                        core_st <= CORE_IDLE;
                    end
                end
                CORE_STEP: begin
                    if (core_instr_done) begin
                        core_st <= CORE_IDLE;
                    end
                end
                default: core_st <= CORE_IDLE;
            endcase
        end
    end

    logic idle;
    assign idle = (core_st == CORE_IDLE);

    // Program counter: advances per finished instruction, host loads bytes
    logic [1:0] sel;
    assign sel = cfg[BIT_MSEL_HI:BIT_MSEL_LO];
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prog_counter <= PC_RESET;
        end else if (!idle && core_instr_done) begin
            prog_counter <= prog_counter + 16'h0001;
        end else if (idle && mem_hit && wr_start) begin
            // Host loads only while idle, so no race with the core
            if (sel == SEL_PCL) begin
                prog_counter[7:0] <= din_b;
            end else if (sel == SEL_PCH) begin
                prog_counter[15:8] <= din_b;
            end
        end
    end

    // Host access steering; non-data targets refused while core busy
    logic host_ok;
    assign host_ok = mem_hit & (rd_start | wr_start)
                   & ((sel == SEL_DMEM) | idle);
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            host_target        <= SEL_IMEM;
            host_target_strobe <= 1'b0;
            host_target_write  <= 1'b0;
            host_wr_data       <= 8'h00;
        end else begin
            host_target        <= sel;
            host_target_strobe <= host_ok;
            host_target_write  <= host_ok & wr_start;
            host_wr_data       <= din_b;
        end
    end

    // Mode bits apply to every target alike
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            access_mode <= '0;
        end else begin
            access_mode.latch_rd <= cfg[BIT_LATCH_RD];
            access_mode.latch_wr <= cfg[BIT_LATCH_WR];
            // Fast only matters outside latched write mode
            access_mode.fast_wr  <= cfg[BIT_FAST_WR]
                                    & ~cfg[BIT_LATCH_WR];
        end
    end

    // Data memory arbiter: core wins a tie when the host had the last grant or the port is locked, then turns alternate
    logic host_dreq;
    logic host_pend;
    logic host_want;
    logic last_host;
    logic locked;
    assign host_dreq = mem_hit & (sel == SEL_DMEM) & (rd_start | wr_start);
    // A host start lost to the core is held, since its strobe lasts one cycle
    assign host_want = host_dreq | host_pend;
    assign locked    = remote_lockout_bit | ~bus_hold_pin_b;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            grant_core <= 1'b0;
            grant_host <= 1'b0;
            last_host  <= 1'b1;
            host_pend  <= 1'b0;
        end else begin
            grant_core <= 1'b0;
            grant_host <= 1'b0;
            if (core_dmem_req && (!host_want || locked || last_host)) begin
                grant_core <= 1'b1;
                last_host  <= 1'b0;
                host_pend  <= host_want;
            end else if (host_want) begin
                grant_host <= 1'b1;
                last_host  <= 1'b1;
                host_pend  <= 1'b0;
            end
        end
    end

    // Read-back path and pin drivers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            remote_data_out         <= 8'h00;
            remote_data_oe          <= 1'b0;
            bidir_interrupt_pin_out <= 1'b0;
            bidir_interrupt_pin_oe  <= 1'b0;
            core_running            <= 1'b0;
            core_exec               <= 1'b0;
        end else begin
            remote_data_oe <= port_on & ~rd_b_s;
            if (cfg_hit && rd_start) begin
                remote_data_out <= {mask3, cfg[6:0]};
            end else if (host_ok && rd_start) begin
                case (sel)
                    SEL_DMEM: remote_data_out <= dmem_rd_data;
                    SEL_IMEM: remote_data_out <= imem_rd_data;
                    SEL_PCL:  remote_data_out <= prog_counter[7:0];
                    default:  remote_data_out <= prog_counter[15:8];
                endcase
            end
            bidir_interrupt_pin_out <= mask3;
            bidir_interrupt_pin_oe  <= irq_pin_is_output;
            core_running            <= (core_st == CORE_RUN);
            core_exec               <= ~idle;
        end
    end

    // Checks
    run_starts_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        idle && cfg[BIT_RUN] |=> core_st == CORE_RUN)
        else $error("run bit did not start core");
    stop_waits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        core_st == CORE_RUN && !core_instr_done |=> core_st != CORE_IDLE)
        else $error("core stopped mid instruction");
    step_one_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        core_st == CORE_STEP && core_instr_done
        |=> idle && prog_counter == $past(prog_counter) + 16'h0001)
        else $error("single step wrong");
    pc_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        idle && !(mem_hit && wr_start) |=> $stable(prog_counter))
        else $error("pc moved while stopped");
    tie_core_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        core_dmem_req && host_dreq && last_host |=> grant_core)
        else $error("core lost tie");
    alt_host_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        host_dreq && !locked && !last_host |=> grant_host)
        else $error("host turn skipped");
    grant_one_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(grant_core && grant_host))
        else $error("double grant");
    fast_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg[BIT_LATCH_WR] |=> !access_mode.fast_wr)
        else $error("fast write in latched mode");
    imem_guard_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !idle && sel != SEL_DMEM |-> !host_ok)
        else $error("host reached core space while busy");
    reset_cfg_a: assert property (@(posedge clk_sys)
        !rst_b |=> cfg == CFG_RESET || boot_run)
        else $error("config reset wrong");
    irq_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_hit && wr_start && din_b[BIT_IRQ_STATUS] && irq_pin_is_output
        |=> mask3 != $past(mask3))
        else $error("interrupt status write did not change pin");
    boot_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        boot_run |=> cfg[BIT_RUN])
        else $error("strap start did not set run");
    pend_served_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        host_pend && !locked && !last_host |=> grant_host)
        else $error("waiting host turn skipped");
    mode_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> access_mode.latch_rd == $past(cfg[BIT_LATCH_RD]))
        else $error("read mode not applied");
    mode_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> access_mode.latch_wr == $past(cfg[BIT_LATCH_WR]))
        else $error("write mode not applied");
    // Covers for the main scenarios
    c_step: cover property (@(posedge clk_sys) core_st == CORE_STEP);
    c_run:  cover property (@(posedge clk_sys) core_st == CORE_RUN);
    c_alt:  cover property (@(posedge clk_sys) grant_core ##1 grant_host);
    c_tie:  cover property (@(posedge clk_sys) core_dmem_req && host_dreq);
    c_boot: cover property (@(posedge clk_sys) boot_run);
endmodule // rhp_port
`default_nettype wire

// File: dv/rhp_host_model.sv
// Behavioural remote host that drives the port pins
`default_nettype none
module rhp_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Remote pins
    output logic            cmd_select_pin,
    output logic            remote_access_enable_pin_b,
    output logic            remote_read_strobe_b,
    output logic            remote_write_strobe_b,
    output logic      [7:0] remote_data_in,
    input  wire logic [7:0] remote_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pins: port disabled, strobes high
    initial begin
        cmd_select_pin = 1'b0;
        remote_access_enable_pin_b = 1'b1;
        remote_read_strobe_b = 1'b1;
        remote_write_strobe_b = 1'b1;
        remote_data_in = 8'h5a;
    end
    // One access; low and high phases both outlast the synchroniser
    task automatic access(input logic cmd, input logic wr,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys);
        cmd_select_pin = cmd;
        remote_access_enable_pin_b = 1'b0;
        remote_data_in = d;
        if (wr) remote_write_strobe_b = 1'b0;
        else remote_read_strobe_b = 1'b0;
        repeat (6) @(negedge clk_sys);
        q = remote_data_out;
        remote_read_strobe_b = 1'b1;
        remote_write_strobe_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        remote_access_enable_pin_b = 1'b1;
        remote_data_in = ~d; // Released data never keeps its last value
    endtask
    // Stand-alone start: both strobes low across reset, port disabled
    task automatic boot_strap(input logic on);
        remote_read_strobe_b = !on;
        remote_write_strobe_b = !on;
    endtask
endmodule // rhp_host_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the remote host port block
`default_nettype none
module tb_top;
    import rhp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_b, cmd_select_pin, remote_access_enable_pin_b;
    logic remote_read_strobe_b, remote_write_strobe_b, remote_data_oe;
    logic [7:0] remote_data_in, remote_data_out, imem_rd_data, dmem_rd_data;
    logic bidir_interrupt_pin_in, bidir_interrupt_pin_out;
    logic bidir_interrupt_pin_oe, remote_lockout_bit, bus_hold_pin_b;
    logic irq_pin_is_output, core_instr_done, core_dmem_req, core_running;
    logic core_exec, host_target_strobe, host_target_write, grant_core;
    logic grant_host;
    logic [15:0] prog_counter;
    logic [1:0] host_target;
    logic [7:0] host_wr_data, q, v;
    rhp_mode_t access_mode;
    logic [10:0] exp_q[$];
    logic [10:0] exp_n;
    logic [31:0] seed, r;
    int n_mismatch, comparisons, n_gc, n_gh, first_gc, n_oe;
    rhp_port dut_u (.clk_sys, .rst_b, .cmd_select_pin,
        .remote_access_enable_pin_b, .remote_read_strobe_b,
        .remote_write_strobe_b, .remote_data_in, .remote_data_out,
        .remote_data_oe, .bidir_interrupt_pin_in, .bidir_interrupt_pin_out,
        .bidir_interrupt_pin_oe, .remote_lockout_bit, .bus_hold_pin_b,
        .irq_pin_is_output, .core_instr_done, .core_dmem_req, .imem_rd_data,
        .dmem_rd_data, .core_running, .core_exec, .prog_counter,
        .host_target, .host_target_strobe, .host_target_write,
        .host_wr_data, .grant_core, .grant_host, .access_mode);
    rhp_host_model host_u (.clk_sys, .cmd_select_pin,
        .remote_access_enable_pin_b, .remote_read_strobe_b,
        .remote_write_strobe_b, .remote_data_in, .remote_data_out);
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want,
                         input string msg);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h want %h", $time, msg,
                     seen, want);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cfg_wr(input logic [7:0] d);
        host_u.access(1'b1, 1'b1, d, q);
    endtask
    task automatic cfg_rd(output logic [7:0] d);
        host_u.access(1'b1, 1'b0, 8'h00, d);
    endtask
    // Memory write; the note is queued only when the port must accept it
    task automatic mem_wr(input logic [7:0] d, input logic [1:0] tgt,
                          input logic ok);
        if (ok) exp_q.push_back({tgt, 1'b1, d});
        host_u.access(1'b0, 1'b1, d, q);
    endtask
    task automatic pulse_done;
        @(negedge clk_sys) core_instr_done = 1'b1;
        @(negedge clk_sys) core_instr_done = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic do_reset;
        rst_b = 1'b0;
        repeat (8) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask
    // Monitor: outputs are settled at the falling edge, pulses seen once
    always @(negedge clk_sys) begin
        if (host_target_strobe === 1'b1) begin
            if (exp_q.size() == 0) check(16'h1, 16'h0, "unexpected access");
            else begin
                exp_n = exp_q.pop_front();
                check({host_target, host_target_write, host_wr_data},
                      exp_n, "host access");
            end
        end
        if (grant_core === 1'b1 && n_gc == 0 && n_gh == 0) first_gc = 1;
        if (grant_core === 1'b1) n_gc++;
        if (grant_host === 1'b1) n_gh++;
        if (remote_data_oe === 1'b1) n_oe++;
    end
    // Watchdog so a stuck design still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        complete_run;
    end
    initial begin
        seed = 32'h45e9cc8b;
        rst_b = 1'b0;
        remote_lockout_bit = 1'b0;
        bus_hold_pin_b = 1'b1;
        irq_pin_is_output = 1'b0;
        core_instr_done = 1'b0;
        core_dmem_req = 1'b0;
        bidir_interrupt_pin_in = 1'b0;
        imem_rd_data = 8'h00;
        dmem_rd_data = 8'h00;
        do_reset;
        check(prog_counter, PC_RESET, "pc after reset");
        check(host_target, SEL_IMEM, "select after reset");
        check({access_mode, core_exec}, 16'h0, "modes after reset");
        cfg_rd(v);
        check(v, CFG_RESET, "config after reset");
        // Every mode combination with a random target and write
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            imem_rd_data = r[15:8];
            dmem_rd_data = r[23:16];
            v = {2'b00, i[2:0], 1'b0, r[1:0]};
            cfg_wr(v);
            check(access_mode, {i[1], i[0], i[2] & ~i[0]}, "mode");
            cfg_rd(q);
            check(q, v, "config readback");
            mem_wr(r[31:24], r[1:0], 1'b1);
            // Read back through the same target and mode
            exp_q.push_back({r[1:0], 1'b0, 8'h00});
            host_u.access(1'b0, 1'b0, 8'h00, q);
            case (r[1:0])
                SEL_DMEM: v = r[23:16];
                SEL_IMEM: v = r[15:8];
                default:  v = r[31:24];
            endcase
            check(q, v, "host read");
        end
        cfg_wr(8'h02);
        mem_wr(8'h34, SEL_PCL, 1'b1);
        cfg_wr(8'h03);
        mem_wr(8'h12, SEL_PCH, 1'b1);
        check(prog_counter, 16'h1234, "pc bytes");
        // Locked out: the config write must not land
        remote_lockout_bit = 1'b1;
        cfg_wr(8'h38);
        remote_lockout_bit = 1'b0;
        cfg_rd(q);
        check(q, 8'h03, "locked write");
        // Core and host both after data memory
        cfg_wr(8'h00);
        n_gc = 0;
        n_gh = 0;
        first_gc = 0;
        // Core request lands on the edge of the host's start: a true tie
        fork
            mem_wr(8'ha5, SEL_DMEM, 1'b1);
            begin
                repeat (3) @(negedge clk_sys);
                core_dmem_req = 1'b1;
                repeat (4) @(negedge clk_sys);
                core_dmem_req = 1'b0;
            end
        join
        check(first_gc, 1, "core first");
        check(n_gh, 1, "host granted");
        check(n_gc > 1, 1'b1, "core granted again");
        // Run from the current counter; refused imem access while running
        cfg_wr(8'h04);
        check({core_running, prog_counter}, 17'h11234, "run start");
        cfg_wr(8'h05);
        mem_wr(8'h77, SEL_IMEM, 1'b0);
        cfg_wr(8'h01);
        check(core_exec, 1'b1, "finishing instruction");
        pulse_done;
        check({core_running, core_exec}, 2'b00, "idle after stop");
        check(prog_counter, 16'h1235, "pc after last instruction");
        repeat (20) @(negedge clk_sys);
        check(prog_counter, 16'h1235, "pc held while stopped");
        // Single step
        cfg_wr(8'h41);
        check(core_exec, 1'b1, "step running");
        pulse_done;
        check({core_exec, prog_counter}, {1'b0, 16'h1236}, "step done");
        n_oe = 0;
        cfg_rd(q);
        check(q, 8'h01, "step bit clears");
        check(n_oe, 6, "read drive window");
        // Interrupt pin as input, then as output toggled by the host
        bidir_interrupt_pin_in = 1'b1;
        cfg_rd(q);
        check(q[7], 1'b1, "pin status");
        bidir_interrupt_pin_in = 1'b0;
        irq_pin_is_output = 1'b1;
        cfg_rd(q);
        v = {~q[7], 7'h01};
        cfg_wr(8'h81);
        check({bidir_interrupt_pin_oe, bidir_interrupt_pin_out}, {1'b1, v[7]},
              "irq toggled");
        cfg_rd(q);
        check(q, v, "status mirrors mask");
        // Second reset with stand-alone start strapping
        host_u.boot_strap(1'b1);
        do_reset;
        host_u.boot_strap(1'b0);
        check({core_running, prog_counter}, 17'h10000, "boot running");
        check(exp_q.size(), 0, "queue drained");
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
